//--- rtl/pmmc_params.svh
// timing counts, memory-map offsets, field positions and reset values
`ifndef PMMC_PARAMS_SVH
`define PMMC_PARAMS_SVH
`define PMMC_CLK_KHZ        40000
`define PMMC_RESET_MIN_NS   10000
`define PMMC_RESET_MIN_CYC  ((`PMMC_RESET_MIN_NS * `PMMC_CLK_KHZ + 999999) / 1000000)
`define PMMC_INIT_TIME_MS   2000
`define PMMC_INIT_CYC       (`PMMC_INIT_TIME_MS * `PMMC_CLK_KHZ)
`define PMMC_NUM_CHAN       4
`define PMMC_DEV_ADDR       7'h50
`define PMMC_PIN_IDLE       5'h1B
`define PMMC_OFS_STATUS     8'h02
`define PMMC_OFS_FLAGS      8'h03
`define PMMC_OFS_CHAN_DIS   8'h56
`define PMMC_OFS_PWR_CTL    8'h5D
`define PMMC_BIT_DNR        0
`define PMMC_BIT_DONE       4
`define PMMC_BIT_FORCE_LP   0
`define PMMC_CHAN_DIS_RST   8'h00
`define PMMC_FLAGS_RST      8'h00
`define PMMC_PWR_CTL_RST    1'b0
`endif

//--- rtl/pmmc_pkg.sv
// state types of the module management block
package pmmc_pkg;
	typedef enum logic [2:0] {
		TW_IDLE  = 3'b000,
		TW_ADDR  = 3'b001,
		TW_ACK_A = 3'b010,
		TW_WDATA = 3'b011,
		TW_ACK_W = 3'b100,
		TW_RDATA = 3'b101,
		TW_RACK  = 3'b110
	} pmmc_tw_state_e;
	typedef enum logic [1:0] {
		MS_INIT  = 2'b00,
		MS_READY = 2'b01,
		MS_HOLD  = 2'b10
	} pmmc_mgmt_state_e;
endpackage

//--- rtl/pmmc_top.sv
// low-speed management and control logic of a four-lane pluggable module
//
// Overview of operation
// - answer serial traffic only while select low
// - long reset pulse restores every default setting
// - completion raises interrupt, clears not-ready flag
// - power-up raises completion interrupt without reset
// - low-power input caps the power level
// - presence pin pulled low while fitted
// - interrupt pin low on fault or status
// - four channels addressable, unused ones shut down
// - serial clock and data serve memory map
// - seven low-speed control pins are provided
`timescale 1ns/10ps
`include "pmmc_params.svh"
module pmmc_top import pmmc_pkg::*; #(
	parameter int unsigned NCH      = `PMMC_NUM_CHAN,
	parameter int unsigned INIT_CYC = `PMMC_INIT_CYC
) (
	// clock and reset
	input  wire logic           mclk,
	input  wire logic           rst,
	// host control inputs
	input  wire logic           module_select_n,
	input  wire logic           module_reset_n,
	input  wire logic           low_power_select,
	// two-wire serial bus
	input  wire logic           scl_line,
	input  wire logic           sda_line,
	output logic                sda_drive,
	output logic                sda_oe,
	// open-collector status pins
	output logic                module_present_n_drive,
	output logic                module_present_n_oe,
	output logic                attention_irq_n_drive,
	output logic                attention_irq_n_oe,
	// module core side
	input  wire logic [NCH-1:0] chan_fault,
	output logic [NCH-1:0]      chan_shutdown,
	output logic                low_power_mode,
	output logic                data_not_ready
);
	localparam int unsigned RST_CYC = `PMMC_RESET_MIN_CYC;
	localparam int unsigned RW      = $clog2(RST_CYC + 1);
	localparam int unsigned IW      = $clog2(INIT_CYC + 1);
	localparam logic [RW-1:0] RST_LAST  = RW'(RST_CYC);
	localparam logic [IW-1:0] INIT_LAST = IW'(INIT_CYC - 1);

	// pin synchronisers
	logic [4:0] meta_r;
	logic [4:0] sync_r;
	logic       sel_n_s;
	logic       rstn_s;
	logic       lp_s;
	logic       scl_s;
	logic       sda_s;

	// reset filter and management state
	logic [RW-1:0]    low_cnt_r;
	logic             long_low;
	logic [IW-1:0]    init_cnt_r;
	logic             done_pulse;
	pmmc_mgmt_state_e state_r;

	// memory map
	logic [NCH-1:0] chan_dis_r;
	logic           force_lp_r;
	logic [7:0]     flags_r;
	logic [7:0]     flag_set;
	logic           flag_clr;
	logic [7:0]     rd_byte;

	// serial engine hookup
	logic [7:0] tw_ptr;
	logic [7:0] tw_acc;
	logic       tw_wr;
	logic [7:0] tw_wdata;
	logic       tw_rd;
	logic       drive_lo_r;

	// all five control inputs are asynchronous to mclk
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_r <= `PMMC_PIN_IDLE;
			sync_r <= `PMMC_PIN_IDLE;
		end else begin
			meta_r <= {module_select_n, module_reset_n, low_power_select,
				scl_line, sda_line};
			sync_r <= meta_r;
		end
	end

	assign sel_n_s = sync_r[4];
	assign rstn_s  = sync_r[3];
	assign lp_s    = sync_r[2];
	assign scl_s   = sync_r[1];
	assign sda_s   = sync_r[0];

	// glitches on the reset pin shorter than the minimum are not a reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			low_cnt_r <= '0;
		end else if (rstn_s) begin
			low_cnt_r <= '0;
		end else if (low_cnt_r != RST_LAST) begin
			low_cnt_r <= low_cnt_r + RW'(1);
		end
	end

	assign long_low = !rstn_s && low_cnt_r == RST_LAST;

	assign done_pulse = state_r == MS_INIT && init_cnt_r == INIT_LAST && !long_low;

	// power-up lands in init, so completion is flagged with no host pulse
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r <= MS_INIT;
		end else if (long_low) begin
			state_r <= MS_HOLD;
		end else begin
			case (state_r)
			MS_INIT:  if (done_pulse) state_r <= MS_READY;
			MS_READY: state_r <= MS_READY;
			MS_HOLD:  if (rstn_s) state_r <= MS_INIT;
			default:  state_r <= MS_INIT;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			init_cnt_r <= '0;
		end else if (state_r != MS_INIT || long_low) begin
			init_cnt_r <= '0;
		end else if (!done_pulse) begin
			init_cnt_r <= init_cnt_r + IW'(1);
		end
	end

	// status stays not-ready from reset until init completes
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			data_not_ready <= 1'b1;
		end else if (long_low || state_r == MS_HOLD) begin
			data_not_ready <= 1'b1;
		end else if (done_pulse) begin
			data_not_ready <= 1'b0;
		end
	end

	// host-written settings fall back to defaults during a module reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			chan_dis_r <= NCH'(`PMMC_CHAN_DIS_RST);
			force_lp_r <= `PMMC_PWR_CTL_RST;
		end else if (long_low || state_r == MS_HOLD) begin
			chan_dis_r <= NCH'(`PMMC_CHAN_DIS_RST);
			force_lp_r <= `PMMC_PWR_CTL_RST;
		end else if (tw_wr) begin
			if (tw_acc == `PMMC_OFS_CHAN_DIS) begin
				chan_dis_r <= tw_wdata[NCH-1:0];
			end
			if (tw_acc == `PMMC_OFS_PWR_CTL) begin
				force_lp_r <= tw_wdata[`PMMC_BIT_FORCE_LP];
			end
		end
	end

	// faults are only latched once status is valid
	always_comb begin
		flag_set = 8'h00;
		if (state_r == MS_READY) begin
			flag_set[NCH-1:0] = chan_fault;
		end
		flag_set[`PMMC_BIT_DONE] = done_pulse;
	end

	assign flag_clr = tw_rd && tw_acc == `PMMC_OFS_FLAGS;

	// clear on read; a new event in the same cycle survives the clear
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			flags_r <= `PMMC_FLAGS_RST;
		end else if (long_low || state_r == MS_HOLD) begin
			flags_r <= `PMMC_FLAGS_RST;
		end else if (flag_clr) begin
			flags_r <= flag_set;
		end else begin
			flags_r <= flags_r | flag_set;
		end
	end

	// unmapped offsets read as zero
	always_comb begin
		rd_byte = 8'h00;
		case (tw_ptr)
		`PMMC_OFS_STATUS:   rd_byte[`PMMC_BIT_DNR] = data_not_ready;
		`PMMC_OFS_FLAGS:    rd_byte = flags_r;
		`PMMC_OFS_CHAN_DIS: rd_byte[NCH-1:0] = chan_dis_r;
		`PMMC_OFS_PWR_CTL:  rd_byte[`PMMC_BIT_FORCE_LP] = force_lp_r;
		default:            rd_byte = 8'h00;
		endcase
	end

	pmmc_twi_slave u_twi (
		.mclk     (mclk),
		.rst      (rst),
		.scl_s    (scl_s),
		.sda_s    (sda_s),
		.enable   (~sel_n_s),
		.sda_oe   (sda_oe),
		.ptr      (tw_ptr),
		.acc_addr (tw_acc),
		.wr_stb   (tw_wr),
		.wr_data  (tw_wdata),
		.rd_stb   (tw_rd),
		.rd_data  (rd_byte)
	);

	// every open-collector pin only ever pulls low
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			drive_lo_r <= 1'b0;
		end else begin
			drive_lo_r <= 1'b0;
		end
	end

	assign sda_drive              = drive_lo_r;
	assign module_present_n_drive = drive_lo_r;
	assign attention_irq_n_drive  = drive_lo_r;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			module_present_n_oe <= 1'b1;
		end else begin
			module_present_n_oe <= 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			attention_irq_n_oe <= 1'b0;
		end else begin
			attention_irq_n_oe <= |flags_r;
		end
	end

	// lanes stay dark until the host may trust the status
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			chan_shutdown <= {NCH{1'b1}};
		end else if (state_r != MS_READY) begin
			chan_shutdown <= {NCH{1'b1}};
		end else begin
			chan_shutdown <= chan_dis_r;
		end
	end

	// software can force low power but never lift the pin's cap
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			low_power_mode <= 1'b1;
		end else begin
			low_power_mode <= lp_s | force_lp_r;
		end
	end

	chk_long_reset_hold: assert property (@(posedge mclk) disable iff (rst)
		long_low |=> (state_r == MS_HOLD && data_not_ready && chan_dis_r == '0 && !force_lp_r))
		else $error("long reset pulse did not restore defaults");
	chk_done_irq_seq: assert property (@(posedge mclk) disable iff (rst)
		done_pulse |=> (state_r == MS_READY && !data_not_ready) ##1 attention_irq_n_oe)
		else $error("reset completion not signalled");
	chk_init_not_ready: assert property (@(posedge mclk) disable iff (rst)
		(state_r == MS_INIT) |-> (data_not_ready && !flags_r[`PMMC_BIT_DONE]))
		else $error("status ready before init completed");
	chk_low_power_cap: assert property (@(posedge mclk) disable iff (rst)
		lp_s |=> low_power_mode)
		else $error("low power input not honoured");
	chk_present_drive: assert property (@(posedge mclk) disable iff (rst)
		module_present_n_oe && !module_present_n_drive)
		else $error("presence pin released");
	chk_fault_irq_sig: assert property (@(posedge mclk) disable iff (rst)
		(state_r == MS_READY && |chan_fault && !long_low) |-> ##2 attention_irq_n_oe)
		else $error("fault did not raise interrupt");
	chk_chan_dark: assert property (@(posedge mclk) disable iff (rst)
		(state_r != MS_READY) |=> chan_shutdown == {NCH{1'b1}})
		else $error("channel enabled before ready");
	chk_irq_release: assert property (@(posedge mclk) disable iff (rst)
		(flags_r == 8'h00) |=> !attention_irq_n_oe)
		else $error("interrupt held with no flag set");
	chk_irq_held: assert property (@(posedge mclk) disable iff (rst)
		(|flags_r && !flag_clr && !long_low && state_r != MS_HOLD) |=> ##1
		attention_irq_n_oe)
		else $error("interrupt dropped without a read");
endmodule

//--- rtl/pmmc_twi_slave.sv
// two-wire serial slave byte engine serving the memory map
`timescale 1ns/10ps
`include "pmmc_params.svh"
module pmmc_twi_slave import pmmc_pkg::*; (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// synchronised bus lines and select
	input  wire logic       scl_s,
	input  wire logic       sda_s,
	input  wire logic       enable,
	output logic            sda_oe,
	// memory-map access
	output logic [7:0]      ptr,
	output logic [7:0]      acc_addr,
	output logic            wr_stb,
	output logic [7:0]      wr_data,
	output logic            rd_stb,
	input  wire logic [7:0] rd_data
);
	logic           scl_d_r;
	logic           sda_d_r;
	logic           scl_rise;
	logic           scl_fall;
	logic           start_c;
	logic           stop_c;
	pmmc_tw_state_e state_r;
	logic [3:0]     cnt_r;
	logic [7:0]     shift_r;
	logic           rw_r;
	logic           first_r;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d_r;
	assign scl_fall = ~scl_s & scl_d_r;
	assign start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;

	// no clock stretching: every answer bit is set up on the scl fall
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r  <= TW_IDLE;
			cnt_r    <= 4'h0;
			shift_r  <= 8'h00;
			rw_r     <= 1'b0;
			first_r  <= 1'b0;
			sda_oe   <= 1'b0;
			ptr      <= 8'h00;
			acc_addr <= 8'h00;
			wr_stb   <= 1'b0;
			wr_data  <= 8'h00;
			rd_stb   <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
			if (!enable || stop_c) begin
				state_r <= TW_IDLE;
				sda_oe  <= 1'b0;
			end else if (start_c) begin
				state_r <= TW_ADDR;
				cnt_r   <= 4'h0;
				sda_oe  <= 1'b0;
			end else begin
				case (state_r)
				TW_ADDR: begin
					if (scl_rise) begin
						shift_r <= {shift_r[6:0], sda_s};
						cnt_r   <= cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == 4'h8) begin
						if (shift_r[7:1] == `PMMC_DEV_ADDR) begin
							state_r <= TW_ACK_A;
							rw_r    <= shift_r[0];
							sda_oe  <= 1'b1;
						end else begin
							state_r <= TW_IDLE;
						end
					end
				end
				TW_ACK_A: if (scl_fall) begin
					cnt_r   <= 4'h0;
					first_r <= 1'b1;
					if (rw_r) begin
						state_r <= TW_RDATA;
						shift_r <= rd_data;
						sda_oe  <= ~rd_data[7];
					end else begin
						state_r <= TW_WDATA;
						sda_oe  <= 1'b0;
					end
				end
				TW_WDATA: begin
					if (scl_rise) begin
						shift_r <= {shift_r[6:0], sda_s};
						cnt_r   <= cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == 4'h8) begin
						state_r <= TW_ACK_W;
						sda_oe  <= 1'b1;
						first_r <= 1'b0;
						if (first_r) begin
							ptr <= shift_r;
						end else begin
							wr_stb   <= 1'b1;
							wr_data  <= shift_r;
							acc_addr <= ptr;
							ptr      <= ptr + 8'h01;
						end
					end
				end
				TW_ACK_W: if (scl_fall) begin
					state_r <= TW_WDATA;
					cnt_r   <= 4'h0;
					sda_oe  <= 1'b0;
				end
				TW_RDATA: begin
					if (scl_rise) begin
						cnt_r <= cnt_r + 4'h1;
					end else if (scl_fall) begin
						if (cnt_r == 4'h8) begin
							state_r  <= TW_RACK;
							sda_oe   <= 1'b0;
							rd_stb   <= 1'b1;
							acc_addr <= ptr;
							ptr      <= ptr + 8'h01;
						end else begin
							shift_r <= {shift_r[6:0], 1'b0};
							sda_oe  <= ~shift_r[6];
						end
					end
				end
				TW_RACK: begin
					if (scl_rise && sda_s) begin
						state_r <= TW_IDLE;
					end else if (scl_fall) begin
						state_r <= TW_RDATA;
						cnt_r   <= 4'h0;
						shift_r <= rd_data;
						sda_oe  <= ~rd_data[7];
					end
				end
				default: state_r <= TW_IDLE;
				endcase
			end
		end
	end

	chk_sel_gate_release: assert property (@(posedge mclk) disable iff (rst)
		!enable |=> !sda_oe)
		else $error("data line driven while deselected");
	chk_addr_ack_drive: assert property (@(posedge mclk) disable iff (rst)
		(state_r == TW_ACK_A || state_r == TW_ACK_W) |-> sda_oe)
		else $error("acknowledge bit not driven low");
endmodule

//--- test/pmmc_host_model.sv
// host controller model: two-wire master with an open-drain data line
`timescale 1ns/10ps
module pmmc_host_model (
	// clock and wire level
	input  wire logic mclk,
	input  wire logic sda_line,
	// host drive, released data reads high through the pull-up
	output logic      scl_line,
	output logic      sda_rel
);
	// serial clock stands high between frames
	initial begin
		scl_line = 1'b1;
		sda_rel  = 1'b1;
	end
	// half of a 200 ns serial clock period
	task automatic half();
		repeat (4) @(negedge mclk);
	endtask
	// also serves as repeated start, scl is low on entry then
	task automatic start();
		sda_rel = 1'b1;
		half();
		scl_line = 1'b1;
		half();
		sda_rel = 1'b0;
		half();
		scl_line = 1'b0;
	endtask
	task automatic stop();
		sda_rel = 1'b0;
		half();
		scl_line = 1'b1;
		half();
		sda_rel = 1'b1;
		half();
	endtask
	// one bit, data set while scl low and sampled at the end of scl high
	task automatic bit_io(input logic b, output logic r);
		sda_rel = b;
		half();
		scl_line = 1'b1;
		half();
		r = sda_line;
		scl_line = 1'b0;
	endtask
	// byte msb first then acknowledge; send 8'hFF to read
	task automatic xfer(input logic [7:0] d, input logic ack_in,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(ack_in, ack);
	endtask
endmodule

//--- test/tb.sv
// self-checking bench of the module management block
`timescale 1ns/10ps
`include "pmmc_params.svh"
module tb;
	localparam int unsigned INIT_CYC = 20;
	localparam logic [7:0]  DONE     = 8'(1 << `PMMC_BIT_DONE);
	localparam logic [7:0]  ADW      = {`PMMC_DEV_ADDR, 1'b0};
	logic       mclk, rst, module_select_n, module_reset_n, low_power_select;
	logic       scl_line, sda_rel, sda_drive, sda_oe, low_power_mode, data_not_ready;
	logic       module_present_n_drive, module_present_n_oe;
	logic       attention_irq_n_drive, attention_irq_n_oe;
	logic [3:0] chan_fault, chan_shutdown;
	int         n_mismatch, cmp_count;
	wire logic  sda_line = sda_rel & (sda_oe ? sda_drive : 1'b1);
	wire logic  irq_pin  = attention_irq_n_oe ? attention_irq_n_drive : 1'b1;
	wire logic  pres_pin = module_present_n_oe ? module_present_n_drive : 1'b1;

	pmmc_top #(.NCH(4), .INIT_CYC(INIT_CYC)) pmmc_top_i (.mclk, .rst, .module_select_n,
		.module_reset_n, .low_power_select, .scl_line, .sda_line, .sda_drive, .sda_oe,
		.module_present_n_drive, .module_present_n_oe, .attention_irq_n_drive,
		.attention_irq_n_oe, .chan_fault, .chan_shutdown, .low_power_mode, .data_not_ready);
	pmmc_host_model pmmc_host_model_i (.mclk, .sda_line, .scl_line, .sda_rel);

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t ns: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("totals: %0d compares, %0d mismatches", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// bounded wait; a lost interrupt would otherwise hang the run
	task automatic wait_irq(input logic lvl);
		int n;
		n = 0;
		while (irq_pin !== lvl && n < 200) begin
			@(negedge mclk);
			n++;
		end
		check(8'(irq_pin), 8'(lvl), "interrupt pin");
		if (n == 200)
			end_sim();
	endtask
	task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d, input logic acked);
		logic [7:0] q;
		logic       a1, a2, a3;
		pmmc_host_model_i.start();
		pmmc_host_model_i.xfer(ADW, 1'b1, q, a1);
		pmmc_host_model_i.xfer(ofs, 1'b1, q, a2);
		pmmc_host_model_i.xfer(d, 1'b1, q, a3);
		pmmc_host_model_i.stop();
		check(8'(a1 | a2 | a3), {7'h00, ~acked}, "write ack");
	endtask
	task automatic reg_rd(input logic [7:0] ofs, input logic [7:0] exp, input string what);
		logic [7:0] q;
		logic       a;
		pmmc_host_model_i.start();
		pmmc_host_model_i.xfer(ADW, 1'b1, q, a);
		pmmc_host_model_i.xfer(ofs, 1'b1, q, a);
		pmmc_host_model_i.start();
		pmmc_host_model_i.xfer(ADW | 8'h01, 1'b1, q, a);
		pmmc_host_model_i.xfer(8'hFF, 1'b1, q, a);
		pmmc_host_model_i.stop();
		check(q, exp, what);
	endtask

	initial begin
		rst = 1'b1;
		module_select_n = 1'b1;
		module_reset_n = 1'b1;
		low_power_select = 1'b0;
		chan_fault = 4'h0;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (5) @(negedge mclk);
		check(8'(pres_pin), 8'h00, "presence");
		rst = 1'b0;
		wait_irq(1'b0);
		check(8'(data_not_ready), 8'h00, "ready");
		module_select_n = 1'b0;
		reg_rd(`PMMC_OFS_STATUS, 8'h00, "status");
		check(8'(irq_pin), 8'h00, "irq held");
		reg_rd(`PMMC_OFS_FLAGS, DONE, "done flag");
		wait_irq(1'b1);
		$display("test power-up done");
		for (int i = 0; i < 4; i++) begin
			reg_wr(`PMMC_OFS_CHAN_DIS, 8'(1 << i), 1'b1);
			check(8'(chan_shutdown), 8'(1 << i), "one lane off");
		end
		reg_wr(`PMMC_OFS_CHAN_DIS, 8'h05, 1'b1);
		reg_rd(`PMMC_OFS_CHAN_DIS, 8'h05, "disable readback");
		reg_rd(8'h10, 8'h00, "unmapped");
		$display("test channels done");
		module_select_n = 1'b1;
		reg_wr(`PMMC_OFS_CHAN_DIS, 8'h0A, 1'b0);
		module_select_n = 1'b0;
		check(8'(chan_shutdown), 8'h05, "deselected write");
		$display("test select done");
		low_power_select = 1'b1;
		repeat (4) @(negedge mclk);
		check(8'(low_power_mode), 8'h01, "lp pin");
		low_power_select = 1'b0;
		repeat (4) @(negedge mclk);
		check(8'(low_power_mode), 8'h00, "lp off");
		reg_wr(`PMMC_OFS_PWR_CTL, 8'h01, 1'b1);
		check(8'(low_power_mode), 8'h01, "lp forced");
		$display("test low power done");
		chan_fault = 4'h4;
		@(negedge mclk);
		chan_fault = 4'h0;
		repeat (2) @(negedge mclk);
		check(8'(irq_pin), 8'h00, "fault irq");
		reg_rd(`PMMC_OFS_FLAGS, 8'h04, "fault flag");
		wait_irq(1'b1);
		$display("test fault done");
		module_reset_n = 1'b0;
		repeat (100) @(negedge mclk);
		module_reset_n = 1'b1;
		repeat (10) @(negedge mclk);
		check(8'(data_not_ready), 8'h00, "short pulse");
		module_reset_n = 1'b0;
		// status is read once while held in reset, before completion
		repeat (420) @(negedge mclk);
		check(8'(data_not_ready), 8'h01, "in reset");
		check(8'(chan_shutdown), 8'h0F, "lanes off");
		reg_rd(`PMMC_OFS_STATUS, 8'h01, "status in reset");
		module_reset_n = 1'b1;
		wait_irq(1'b0);
		reg_rd(`PMMC_OFS_CHAN_DIS, `PMMC_CHAN_DIS_RST, "disable default");
		reg_rd(`PMMC_OFS_PWR_CTL, 8'h00, "force default");
		check(8'(low_power_mode), 8'h00, "lp default");
		reg_rd(`PMMC_OFS_FLAGS, DONE, "done again");
		check(8'(chan_shutdown), 8'h00, "lanes on");
		$display("test reset pin done");
		end_sim();
	end
endmodule
